// file: rtl/gps_ports.sv
/*
  gpio ports b to e with parallel slave mode on port d, avalon-mm slave.
  assumes: pin inputs synchronous to clk_sys_i; peripherals give their own
  enables; an external host drives port e strobes in parallel slave mode.
*/
// Design decision made here: register access over Avalon-MM.
module gps_ports (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire gps_pkg::gps_addr_t avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire gps_pkg::gps_byte_t pb_i,
    output gps_pkg::gps_byte_t pb_out_o,
    output gps_pkg::gps_byte_t pb_oe_o,
    output gps_pkg::gps_byte_t pb_pullup_en_o,
    input wire gps_pkg::gps_byte_t pc_i,
    output gps_pkg::gps_byte_t pc_out_o,
    output gps_pkg::gps_byte_t pc_oe_o,
    input wire gps_pkg::gps_byte_t pd_i,
    output gps_pkg::gps_byte_t pd_out_o,
    output gps_pkg::gps_byte_t pd_oe_o,
    input wire gps_pkg::gps_pe_t pe_i,
    output gps_pkg::gps_pe_t pe_out_o,
    output gps_pkg::gps_pe_t pe_oe_o,
    input wire logic t1osc_en_i,
    input wire logic ccp_en_i,
    input wire logic ccp_out_en_i,
    input wire logic ccp_out_i,
    input wire logic ser_en_i,
    input wire logic ser_ck_oe_i,
    input wire logic ser_ck_out_i,
    input wire logic ser_dt_oe_i,
    input wire logic ser_dt_out_i
);
    import gps_pkg::*;
`include "gps_params.svh"

    // ==========================================================
    // register state
    gps_byte_t pb_lat_q;    // port b output latch
    gps_byte_t pc_lat_q;    // port c output latch
    gps_byte_t pd_lat_q;    // port d latch, also host read byte
    gps_pe_t pe_lat_q;      // port e output latch
    gps_byte_t opt_q;       // pull-up, edge and prescale config
    gps_byte_t pb_dir_q;    // port b direction, 1 = input
    gps_byte_t pc_dir_q;    // port c direction, 1 = input
    gps_byte_t pd_dir_q;    // port d direction, 1 = input
    gps_pe_t pe_dir_q;      // port e direction, 1 = input
    gps_pe_t analog_q;      // 1 = port e pin is analog
    logic psp_q;            // parallel slave select
    logic ibf_q;            // input buffer full
    logic obf_q;            // output buffer full
    logic input_overrun_flag_q;           // input overrun
    gps_byte_t inbuf_q;     // byte written by the host
    logic wr_act_q;         // host write strobe seen last cycle
    logic rd_act_q;         // host read strobe seen last cycle
    logic wait_q;           // avalon waitrequest
    logic [31:0] rdata_q;   // avalon read data

    // ==========================================================
    // bus decode
    logic [7:0] idx;        // register index
    logic acc;              // request accepted this edge
    logic acc_wr;           // accepted write, low byte lane on
    logic acc_rd;           // accepted read
    assign idx = avs_address_i[9:2];
    assign acc = (avs_read_i | avs_write_i) & ~wait_q;
    assign acc_wr = acc & avs_write_i & avs_byteenable_i[0];
    assign acc_rd = acc & avs_read_i;

    // ==========================================================
    // host strobes on port e (active low, qualified by select)
    logic wr_act;           // host write in progress
    logic rd_act;           // host read in progress
    logic wr_end;           // host write just finished
    logic rd_end;           // host read just finished
    assign wr_act = psp_q & ~pe_i[1] & ~pe_i[2];
    assign rd_act = psp_q & ~pe_i[0] & ~pe_i[2];
    assign wr_end = wr_act_q & ~wr_act;
    assign rd_end = rd_act_q & ~rd_act;

    // strobe history for end-of-strobe detection
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
        end else begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
        end
    end

    // ==========================================================
    // avalon handshake: one wait cycle, then one accept cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 1'b1;
        end else if ((avs_read_i | avs_write_i) & wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // ==========================================================
    // read mux; unmapped indexes read as zero
    gps_byte_t rd_val;
    always_comb begin
        rd_val = 8'h00;
        case (idx)
            // data registers return pin levels
            `GPS_IDX_PB_DATA: rd_val = pb_i;
            `GPS_IDX_PC_DATA: rd_val = pc_i;
            // slave mode returns the host byte instead
            `GPS_IDX_PD_DATA: rd_val = psp_q ? inbuf_q : pd_i;
            // analog pins read zero, top bits zero
            `GPS_IDX_PE_DATA: rd_val = {5'h00, pe_i & ~analog_q};
            `GPS_IDX_ANALOG: rd_val = {5'h00, analog_q};
            `GPS_IDX_OPTION: rd_val = opt_q;
            `GPS_IDX_PB_DIR: rd_val = pb_dir_q;
            `GPS_IDX_PC_DIR: rd_val = pc_dir_q;
            `GPS_IDX_PD_DIR: rd_val = pd_dir_q;
            // bit 3 is unimplemented
            `GPS_IDX_PE_DIR: rd_val = {ibf_q, obf_q, input_overrun_flag_q, psp_q, 1'b0, pe_dir_q};
            default: rd_val = 8'h00;
        endcase
    end

    // read data is loaded on the wait edge and held through accept
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i & wait_q) begin
            rdata_q <= {24'h00_0000, rd_val};
        end
    end

    // ==========================================================
    // software-written configuration
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opt_q <= `GPS_RST_BYTE;
            pb_dir_q <= `GPS_RST_BYTE;
            pc_dir_q <= `GPS_RST_BYTE;
            pd_dir_q <= `GPS_RST_BYTE;
            pe_dir_q <= `GPS_RST_PE_DIR;
            analog_q <= `GPS_RST_ANALOG;
            psp_q <= 1'b0;
        end else if (acc_wr) begin
            case (idx)
                `GPS_IDX_OPTION: opt_q <= avs_writedata_i[7:0];
                `GPS_IDX_PB_DIR: pb_dir_q <= avs_writedata_i[7:0];
                `GPS_IDX_PC_DIR: pc_dir_q <= avs_writedata_i[7:0];
                `GPS_IDX_PD_DIR: pd_dir_q <= avs_writedata_i[7:0];
                `GPS_IDX_ANALOG: analog_q <= avs_writedata_i[2:0];
                `GPS_IDX_PE_DIR: begin
                    pe_dir_q <= avs_writedata_i[2:0];
                    psp_q <= avs_writedata_i[`GPS_F_PSP];
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // output latches; a port d write in slave mode fills the host read byte
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pb_lat_q <= `GPS_RST_LATCH;
            pc_lat_q <= `GPS_RST_LATCH;
            pd_lat_q <= `GPS_RST_LATCH;
            pe_lat_q <= 3'h0;
        end else if (acc_wr) begin
            case (idx)
                `GPS_IDX_PB_DATA: pb_lat_q <= avs_writedata_i[7:0];
                `GPS_IDX_PC_DATA: pc_lat_q <= avs_writedata_i[7:0];
                `GPS_IDX_PD_DATA: pd_lat_q <= avs_writedata_i[7:0];
                `GPS_IDX_PE_DATA: pe_lat_q <= avs_writedata_i[2:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // parallel slave input byte: sampled while the host strobe is low,
    // so the last value before the strobe rises is kept
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inbuf_q <= 8'h00;
        end else if (wr_act) begin
            inbuf_q <= pd_i;
        end
    end

    // ==========================================================
    // slave status flags; in each the set wins over the clear
    logic cpu_rd_pd;   // processor reads the host byte
    logic cpu_wr_pd;   // processor writes the host read byte
    logic sw_input_overrun_flag_clr; // software writes zero to the overrun bit
    assign cpu_rd_pd = acc_rd & psp_q & (idx == `GPS_IDX_PD_DATA);
    assign cpu_wr_pd = acc_wr & psp_q & (idx == `GPS_IDX_PD_DATA);
    assign sw_input_overrun_flag_clr = acc_wr & (idx == `GPS_IDX_PE_DIR) & ~avs_writedata_i[`GPS_F_INPUT_OVERRUN_FLAG];

    // input full: set by host write end, cleared by processor read
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ibf_q <= 1'b0;
        end else if (wr_end) begin
            ibf_q <= 1'b1;
        end else if (cpu_rd_pd) begin
            ibf_q <= 1'b0;
        end
    end

    // overrun: only software clears it
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            input_overrun_flag_q <= 1'b0;
        end else if (wr_end & ibf_q) begin
            input_overrun_flag_q <= 1'b1;
        end else if (sw_input_overrun_flag_clr) begin
            input_overrun_flag_q <= 1'b0;
        end
    end

    // output full: set by processor write, cleared by host read end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            obf_q <= 1'b0;
        end else if (cpu_wr_pd) begin
            obf_q <= 1'b1;
        end else if (rd_end) begin
            obf_q <= 1'b0;
        end
    end

    // ==========================================================
    // port c peripheral overrides, fixed pin mapping
    gps_byte_t ovr_en;   // peripheral owns the direction
    gps_byte_t ovr_oe;   // forced direction, 1 = output
    gps_byte_t ovr_out;  // peripheral output value
    // timer1 oscillator forces pins 0,1 to inputs
    // capture/compare/pwm owns pin 2
    // serial clock on pin 6, data on pin 7
    assign ovr_en = {ser_en_i, ser_en_i, 3'h0, ccp_en_i, t1osc_en_i, t1osc_en_i};
    assign ovr_oe = {ser_dt_oe_i, ser_ck_oe_i, 3'h0, ccp_out_en_i, 2'h0};
    assign ovr_out = {ser_dt_out_i, ser_ck_out_i, 3'h0, ccp_out_i, 2'h0};

    // ==========================================================
    // pin drivers, all registered
    gps_byte_t pc_oe_d;   // next port c enables
    gps_byte_t pc_out_d;  // next port c outputs
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pc
            // override beats the stored bit; else 1 tristates, 0 drives
            assign pc_oe_d[gi] = ovr_en[gi] ? ovr_oe[gi] : ~pc_dir_q[gi];
            assign pc_out_d[gi] = ovr_en[gi] ? ovr_out[gi] : pc_lat_q[gi];
        end
    endgenerate

    // ports b and c follow their direction registers
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pb_out_o <= 8'h00;
            pb_oe_o <= 8'h00;
            pb_pullup_en_o <= 8'h00;
            pc_out_o <= 8'h00;
            pc_oe_o <= 8'h00;
        end else begin
            pb_out_o <= pb_lat_q;
            pb_oe_o <= ~pb_dir_q;
            // pull-ups only on inputs, enabled by a low control bit
            pb_pullup_en_o <= {8{~opt_q[`GPS_F_PULLUP_N]}} & pb_dir_q;
            pc_out_o <= pc_out_d;
            pc_oe_o <= pc_oe_d;
        end
    end

    // port d: gpio per bit, or driven only while the host reads
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pd_out_o <= 8'h00;
            pd_oe_o <= 8'h00;
        end else begin
            pd_out_o <= pd_lat_q;
            pd_oe_o <= psp_q ? {8{rd_act}} : ~pd_dir_q;
        end
    end

    // port e: direction bits drive even on analog pins; software must
    // keep strobe pins as inputs in slave mode or it fights the host
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pe_out_o <= 3'h0;
            pe_oe_o <= 3'h0;
        end else begin
            pe_out_o <= pe_lat_q;
            pe_oe_o <= ~pe_dir_q;
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    pc_input_a: assert property (pc_dir_q[3] |=> !pc_oe_o[3])
        else $error("port c input pin is driven");
    pc_output_a: assert property (!pc_dir_q[4] |=> pc_oe_o[4] && pc_out_o[4] == $past(pc_lat_q[4]))
        else $error("port c output pin not driven from latch");
    pc_override_a: assert property (t1osc_en_i && !pc_dir_q[0] |=> !pc_oe_o[0])
        else $error("timer1 pin not forced to input");
    pc_ccp_map_a: assert property (ccp_en_i && ccp_out_en_i |=> pc_oe_o[2] && pc_out_o[2] == $past(ccp_out_i))
        else $error("capture compare pin mapping wrong");
    pc_serial_map_a: assert property (ser_en_i && ser_ck_oe_i |=> pc_oe_o[6] && pc_out_o[6] == $past(ser_ck_out_i))
        else $error("serial clock pin mapping wrong");
    pd_gpio_dir_a: assert property (!psp_q |=> pd_oe_o == ~$past(pd_dir_q))
        else $error("port d direction wrong in gpio mode");
    pd_host_read_a: assert property (psp_q && !pe_i[0] && !pe_i[2] |=> pd_oe_o == 8'hFF)
        else $error("port d not driven during host read");
    pd_host_idle_a: assert property (psp_q && pe_i[2] |=> pd_oe_o == 8'h00)
        else $error("port d driven while host unselected");
    pe_analog_zero_a: assert property (acc_rd && idx == `GPS_IDX_PE_DATA && analog_q[1] |=> !avs_readdata_o[1])
        else $error("analog port e pin reads one");
    pe_dir_drive_a: assert property (analog_q[0] && !pe_dir_q[0] |=> pe_oe_o[0])
        else $error("port e direction ignored on analog pin");
    // only a read refreshes the data, so a write would see stale bits
    unimpl_zero_a: assert property (avs_read_i && !wait_q && idx == `GPS_IDX_PE_DIR |->
        !avs_readdata_o[3] && avs_readdata_o[31:8] == 24'h00_0000)
        else $error("unimplemented bits read nonzero");
    input_overrun_flag_set_a: assert property (wr_act_q && !wr_act && ibf_q |=> input_overrun_flag_q)
        else $error("overrun not flagged");
    input_overrun_flag_hold_a: assert property (input_overrun_flag_q && !sw_input_overrun_flag_clr |=> input_overrun_flag_q)
        else $error("overrun cleared without software");
    // set by a processor write, then held until the host read ends
    obf_cycle_a: assert property (cpu_wr_pd || (obf_q && !rd_end) |=> obf_q)
        else $error("output full not held");
    obf_clear_a: assert property (rd_act_q && !rd_act && !cpu_wr_pd |=> !obf_q)
        else $error("output full not cleared by host read");
    por_analog_a: assert property ($rose(rst_n_i) |-> analog_q == 3'h7)
        else $error("port e not analog after reset");
endmodule

// file: rtl/gps_params.svh
/*
  register indexes, field positions and reset values of the gpio ports block.
  assumes: included by bare name from the core module only.
*/
`ifndef GPS_PARAMS_SVH
`define GPS_PARAMS_SVH

// ==========================================================
// register indexes (byte address is four times the index)
`define GPS_IDX_PB_DATA 8'h06
`define GPS_IDX_PC_DATA 8'h07
`define GPS_IDX_PD_DATA 8'h08
`define GPS_IDX_PE_DATA 8'h09
`define GPS_IDX_ANALOG 8'h0A
`define GPS_IDX_OPTION 8'h81
`define GPS_IDX_PB_DIR 8'h86
`define GPS_IDX_PC_DIR 8'h87
`define GPS_IDX_PD_DIR 8'h88
`define GPS_IDX_PE_DIR 8'h89

// ==========================================================
// fields of the port e direction and slave control register
`define GPS_F_IBF 7
`define GPS_F_OBF 6
`define GPS_F_INPUT_OVERRUN_FLAG 5
`define GPS_F_PSP 4
// field of the option register: active-low pull-up enable
`define GPS_F_PULLUP_N 7

// ==========================================================
// reset values
`define GPS_RST_BYTE 8'hFF
`define GPS_RST_LATCH 8'h00
`define GPS_RST_PE_DIR 3'h7
`define GPS_RST_ANALOG 3'h7

`endif

// file: rtl/gps_pkg.sv
/*
  types shared by the gpio ports block.
  assumes: compiled before the core module.
*/
package gps_pkg;
    // ==========================================================
    // common types
    typedef logic [7:0] gps_byte_t;   // one port byte
    typedef logic [2:0] gps_pe_t;     // the three port e pins
    typedef logic [9:0] gps_addr_t;   // avalon byte address
endpackage

// file: dv/gps_host_model.sv
/*
  external host model for the parallel slave port: strobes on port e, byte on port d.
  assumes: the bench resolves pin levels and feeds them back on pd_pin_i.
*/
module gps_host_model (
    input wire logic clk_sys_i,
    input wire gps_pkg::gps_byte_t pd_pin_i,
    output gps_pkg::gps_byte_t pd_drv_o,
    output gps_pkg::gps_pe_t pe_drv_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import gps_pkg::*;
    // ==========================================================
    // drive state
    logic drive_q; // host drives the data bus
    gps_byte_t val_q; // last byte put on the bus
    // released bus shows the inverse, so a stale byte never passes as data
    assign pd_drv_o = drive_q ? val_q : ~val_q;
    initial begin
        drive_q = 1'b0;
        val_q = 8'h00;
        pe_drv_o = 3'h7;
    end
    // plain pin levels for gpio use
    task automatic set_pins(input gps_byte_t d, input gps_pe_t e);
        @(posedge clk_sys_i);
        val_q <= d;
        drive_q <= 1'b1;
        pe_drv_o <= e;
    endtask
    // write cycle: select and write strobe low together, data held
    task automatic host_write(input gps_byte_t d);
        @(posedge clk_sys_i);
        val_q <= d;
        drive_q <= 1'b1;
        pe_drv_o <= 3'h1;
        repeat (2) @(posedge clk_sys_i);
        pe_drv_o <= 3'h7;
        @(posedge clk_sys_i);
        drive_q <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask
    // read cycle: select and read strobe low, bus released by the host
    task automatic host_read(output gps_byte_t d);
        @(posedge clk_sys_i);
        drive_q <= 1'b0;
        pe_drv_o <= 3'h2;
        repeat (3) @(posedge clk_sys_i);
        d = pd_pin_i;
        pe_drv_o <= 3'h7;
        repeat (3) @(posedge clk_sys_i);
    endtask
endmodule

// file: dv/gps_ports_tb.sv
/*
  self-checking bench of the gpio ports block over its avalon-mm slave.
  assumes: design files compiled first; pins resolved here from all enables.
*/
module gps_ports_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gps_pkg::*;
    // ==========================================================
    // clock, reset, bus and pins
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    gps_addr_t addr = '0;
    logic rd_req = 1'b0, wr_req = 1'b0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] ben = 4'h0;
    logic waitreq;
    gps_byte_t pb_i, pb_out, pb_oe, pb_pu, pc_i, pc_out, pc_oe, pd_i, pd_out, pd_oe, pd_drv;
    gps_pe_t pe_i, pe_out, pe_oe, pe_drv;
    gps_byte_t pb_ext = 8'h5A, pc_ext = 8'h3C; // external levels on idle pins
    logic t1en = 0, ccpen = 0, ccpoe = 0, ccpo = 0, seren = 0, ckoe = 0, cko = 0;
    logic dtoe = 0, dto = 0;
    int failures = 0, compares = 0;
    gps_byte_t hb;
    always #10 clk_sys = ~clk_sys; // 50 MHz
    // a pin shows the device's drive where enabled, otherwise the outside level
    assign pb_i = (pb_oe & pb_out) | (~pb_oe & pb_ext);
    assign pc_i = (pc_oe & pc_out) | (~pc_oe & pc_ext);
    assign pd_i = (pd_oe & pd_out) | (~pd_oe & pd_drv);
    assign pe_i = (pe_oe & pe_out) | (~pe_oe & pe_drv);
    gps_ports i_gps_ports (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .avs_address_i(addr),
        .avs_read_i(rd_req), .avs_write_i(wr_req), .avs_writedata_i(wdata),
        .avs_byteenable_i(ben), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .pb_i(pb_i), .pb_out_o(pb_out), .pb_oe_o(pb_oe), .pb_pullup_en_o(pb_pu),
        .pc_i(pc_i), .pc_out_o(pc_out), .pc_oe_o(pc_oe), .pd_i(pd_i), .pd_out_o(pd_out),
        .pd_oe_o(pd_oe), .pe_i(pe_i), .pe_out_o(pe_out), .pe_oe_o(pe_oe),
        .t1osc_en_i(t1en), .ccp_en_i(ccpen), .ccp_out_en_i(ccpoe), .ccp_out_i(ccpo),
        .ser_en_i(seren), .ser_ck_oe_i(ckoe), .ser_ck_out_i(cko), .ser_dt_oe_i(dtoe),
        .ser_dt_out_i(dto));
    gps_host_model i_gps_host_model (.clk_sys_i(clk_sys), .pd_pin_i(pd_i),
        .pd_drv_o(pd_drv), .pe_drv_o(pe_drv));
    // ==========================================================
    // verdict, comparison and bus tasks
    task automatic close_out();
        $display("counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one avalon cycle; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        rd_req <= !wr;
        wr_req <= wr;
        addr <= {idx, 2'b00};
        wdata <= {24'h0, wd};
        ben <= 4'hF;
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        rd = rdata[7:0];
        if (!wr) check("readdata high bits", rdata[31:8], 24'h0);
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        if (n >= 50) begin
            failures++;
            $display("BAD waitrequest never dropped");
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] junk;
        bus(1'b1, idx, d, junk);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        bus(1'b0, idx, 8'h00, v);
        check(name, v, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_sys);
    endtask
    // ==========================================================
    // main sequence; full-byte writes only, never read-modify-write
    logic [7:0] ridx [7] = '{8'h81, 8'h86, 8'h87, 8'h88, 8'h89, 8'h0A, 8'h40};
    logic [7:0] rexp [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h07, 8'h00};
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset values, unmapped place reads zero
        for (int i = 0; i < 7; i++) rd_chk("reset value", ridx[i], rexp[i]);
        check("pins idle after reset", {pc_oe, pd_oe, pe_oe}, 19'h0);
        wr(8'h40, 8'hAA);
        rd_chk("unmapped after write", 8'h40, 8'h00);
        $display("test reset done");
        // port c: latch to pins, then peripheral overrides
        wr(8'h07, 8'hA5);
        wr(8'h87, 8'h00);
        settle();
        check("pc enables", pc_oe, 8'hFF);
        check("pc drive", pc_out, 8'hA5);
        rd_chk("pc pins", 8'h07, 8'hA5);
        t1en <= 1; ccpen <= 1; ccpoe <= 1; seren <= 1; ckoe <= 1; dtoe <= 0;
        settle();
        check("pc overridden enables", pc_oe, 8'h7C);
        check("pc overridden drive", pc_out & 8'h7C, 8'h20);
        ccpo <= 1; cko <= 1; dtoe <= 1; dto <= 1;
        wr(8'h87, 8'hFF);
        settle();
        check("pc forced outputs", pc_oe, 8'hC4);
        check("pc forced drive", pc_out & 8'hC4, 8'hC4);
        rd_chk("pc direction kept", 8'h87, 8'hFF);
        t1en <= 0; ccpen <= 0; seren <= 0;
        settle();
        check("pc released", pc_oe, 8'h00);
        // port b: latch, direction and pull-ups on inputs only
        wr(8'h06, 8'h3C);
        wr(8'h86, 8'hF0);
        wr(8'h81, 8'h7F);
        settle();
        check("pb enables", pb_oe, 8'h0F);
        check("pb drive", pb_out, 8'h3C);
        check("pb pull-ups", pb_pu, 8'hF0);
        rd_chk("pb pins", 8'h06, 8'h5C);
        $display("test ports b c done");
        // port d as gpio, per-pin direction
        wr(8'h88, 8'h0F);
        wr(8'h08, 8'hC3);
        i_gps_host_model.set_pins(8'h96, 3'h7);
        settle();
        check("pd enables", pd_oe, 8'hF0);
        rd_chk("pd pins", 8'h08, 8'hC6);
        // port e: analog reads zero, direction still drives
        i_gps_host_model.set_pins(8'h00, 3'h7);
        rd_chk("pe analog", 8'h09, 8'h00);
        wr(8'h89, 8'h0A);
        rd_chk("pe dir bit3", 8'h89, 8'h02);
        settle();
        check("pe enables analog", pe_oe, 3'h5);
        wr(8'h0A, 8'h00);
        wr(8'h09, 8'h04);
        rd_chk("pe digital", 8'h09, 8'h06);
        check("pe drive", pe_out, 3'h4);
        $display("test gpio d e done");
        // parallel slave: inputs set, pins digital
        wr(8'h89, 8'h17);
        wr(8'h88, 8'hFF);
        rd_chk("slave select", 8'h89, 8'h17);
        i_gps_host_model.host_write(8'h3C);
        rd_chk("input full", 8'h89, 8'h97);
        rd_chk("host byte", 8'h08, 8'h3C);
        rd_chk("input drained", 8'h89, 8'h17);
        i_gps_host_model.host_write(8'h11);
        i_gps_host_model.host_write(8'h22);
        rd_chk("overrun set", 8'h89, 8'hB7);
        wr(8'h89, 8'h37);
        rd_chk("overrun kept", 8'h89, 8'hB7);
        wr(8'h89, 8'h17);
        rd_chk("overrun cleared", 8'h89, 8'h97);
        bus(1'b0, 8'h08, 8'h00, hb);
        wr(8'h08, 8'h5A);
        rd_chk("output full", 8'h89, 8'h57);
        i_gps_host_model.host_read(hb);
        check("host read byte", hb, 8'h5A);
        rd_chk("output drained", 8'h89, 8'h17);
        // gpio mode again: strobes ignored
        wr(8'h89, 8'h07);
        i_gps_host_model.host_write(8'h77);
        rd_chk("strobes ignored", 8'h89, 8'h07);
        $display("test slave port done");
        close_out();
    end
endmodule
